// *** src/mc_phase.v ***
// machine cycle state counter, C1 to C4
`timescale 1ns/1ps
`default_nettype none
`include "xdata_map.vh"
module mc_phase (
   // clock and reset
   input  wire       mclk_i,
   input  wire       rstn_i,
   // current clock state inside the machine cycle
   output wire [1:0] phase_o
);

   reg [1:0] phase_q;

   // free running, wraps from C4 back to C1
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_q <= `PH_C1;
      end else begin
         phase_q <= phase_q + 2'h1; // RL18
      end
   end

   assign phase_o = phase_q;

endmodule // mc_phase
`default_nettype wire

// *** src/pin_sync.v ***
// two flip-flop synchroniser for pin inputs, any width
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire             mclk_i,
   input  wire             rstn_i,
   // asynchronous pin level in, synchronised level out
   input  wire [WIDTH-1:0] pin_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage is read only by the second stage
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // pin_sync
`default_nettype wire

// *** src/xdata_access.v ***
// external data transfer unit: address forming, stretch, wait states, registers
`timescale 1ns/1ps
`default_nettype none
`include "xdata_map.vh"
module xdata_access #(
   parameter HAS_WAIT_PIN = 1
) (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rstn_i,
   // avalon-mm register slave, byte address
   input  wire [9:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // cpu side transfer request, sampled in C4 of the fetch cycle
   input  wire        xfer_req_i,
   input  wire        xfer_write_i,
   input  wire        xfer_use_ptr_i,
   input  wire [7:0]  bank_index_i,
   input  wire [7:0]  port2_latch_i,
   input  wire [7:0]  xfer_wdata_i,
   output wire        xfer_busy_o,
   output wire        xfer_done_o,
   output wire [7:0]  xfer_rdata_o,
   output wire [1:0]  phase_o,
   // external memory bus
   output wire [15:0] ext_addr_o,
   output wire [7:0]  ext_data_o,
   output wire        ext_data_oe_o,
   input  wire [7:0]  ext_data_i,
   output wire        ext_rd_n_o,
   output wire        ext_wr_n_o,
   // wait input, alternate use of port4_bit0, active low
   input  wire        port4_bit0_n_i
);

   localparam ST_IDLE   = 1'b0;
   localparam ST_ACCESS = 1'b1;

   // unlock window length; the counter is 8 bits, so the load takes the low byte on purpose
   localparam [31:0] TA_WIN_CLKS = `TA_WINDOW_CLKS;

   // word index of a byte address
   function [7:0] reg_index;
      input [9:0] byte_addr;
      begin
         reg_index = byte_addr[9:2];
      end
   endfunction

   // machine cycle phase and synchronised pins
   wire [1:0] phase;
   wire       wait_n_sync;
   wire [7:0] ext_data_sync;

   // registers software sees
   reg [15:0] data_pointer_a_a_q;
   reg [15:0] data_pointer_a_b_q;
   reg        psel_q;
   reg [7:0]  clk_ctrl_q;
   reg        wait_en_q;

   // timed access unlock
   reg        ta_armed_q;
   reg [7:0]  ta_window_q;

   // bus slave
   reg        waitreq_q;
   reg [31:0] rdata_q;
   reg [7:0]  rd_value;

   // transfer sequencer
   reg        state_q;
   reg        first_q;
   reg        short_q;
   reg [2:0]  cyc_left_q;
   reg        ext_q;
   reg        write_q;
   reg [15:0] addr_q;
   reg [7:0]  wdata_q;
   reg        oe_q;
   reg        rd_n_q;
   reg        wr_n_q;
   reg        busy_q;
   reg        done_q;
   reg [7:0]  xrdata_q;

   wire        bus_req    = avs_read | avs_write;
   wire        bus_commit = bus_req & ~waitreq_q;
   wire        wr_commit  = avs_write & ~waitreq_q;
   wire [7:0]  wr_idx     = reg_index(avs_address);
   wire [7:0]  wr_byte    = avs_writedata[7:0];
   wire [2:0]  stretch    = clk_ctrl_q[`STRETCH_MSB:`STRETCH_LSB]; // RL6
   wire [15:0] sel_ptr    = psel_q ? data_pointer_a_b_q : data_pointer_a_a_q; // RL3
   wire        wait_act   = (HAS_WAIT_PIN != 0) & ~wait_n_sync; // RL17 RL20
   wire        ta_open    = (ta_window_q != 8'h00);

   // wait pin and read data pass two flops before use
   pin_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) u_wait_sync (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .pin_i  (port4_bit0_n_i),
      .sync_o (wait_n_sync)
   );

   pin_sync #(
      .WIDTH   (8),
      .RST_VAL (8'h00)
   ) u_data_sync (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .pin_i  (ext_data_i),
      .sync_o (ext_data_sync)
   );

   mc_phase u_phase (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .phase_o (phase)
   );

   // one wait cycle per access: answer one edge after the request appears
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         waitreq_q <= 1'b1;
         rdata_q   <= 32'h00000000;
      end else if (bus_commit) begin
         waitreq_q <= 1'b1;
      end else if (bus_req) begin
         waitreq_q <= 1'b0;
         rdata_q   <= {24'h000000, rd_value};
      end
   end

   // read mux; unmapped indices read zero
   always @* begin
      if (wr_idx == `IDX_DATA_POINTER_A_A_LO) begin
         rd_value = data_pointer_a_a_q[7:0];
      end else if (wr_idx == `IDX_DATA_POINTER_A_A_HI) begin
         rd_value = data_pointer_a_a_q[15:8];
      end else if (wr_idx == `IDX_DATA_POINTER_A_B_LO) begin
         rd_value = data_pointer_a_b_q[7:0];
      end else if (wr_idx == `IDX_DATA_POINTER_A_B_HI) begin
         rd_value = data_pointer_a_b_q[15:8];
      end else if (wr_idx == `IDX_PTR_SELECT) begin
         rd_value = {7'h00, psel_q}; // RL4
      end else if (wr_idx == `IDX_CLOCK_CTRL) begin
         rd_value = clk_ctrl_q;
      end else if (wr_idx == `IDX_WAIT_CTRL) begin
         rd_value = {wait_en_q, 7'h00};
      end else if (wr_idx == `IDX_XFER_STATUS) begin
         rd_value = {5'h00, wait_en_q, ext_q, busy_q};
      end else begin
         rd_value = 8'h00;
      end
   end

   // software registers; writes land on the edge where waitrequest is seen low
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_pointer_a_a_q   <= `PTR_RST;
         data_pointer_a_b_q   <= `PTR_RST;
         psel_q     <= 1'b0;
         clk_ctrl_q <= `CLOCK_CTRL_RST; // RL10
         wait_en_q  <= 1'b0;
      end else if (wr_commit) begin
         if (wr_idx == `IDX_DATA_POINTER_A_A_LO) begin
            data_pointer_a_a_q[7:0] <= wr_byte;
         end else if (wr_idx == `IDX_DATA_POINTER_A_A_HI) begin
            data_pointer_a_a_q[15:8] <= wr_byte;
         end else if (wr_idx == `IDX_DATA_POINTER_A_B_LO) begin
            data_pointer_a_b_q[7:0] <= wr_byte;
         end else if (wr_idx == `IDX_DATA_POINTER_A_B_HI) begin
            data_pointer_a_b_q[15:8] <= wr_byte;
         end else if (wr_idx == `IDX_PTR_SELECT) begin
            psel_q <= wr_byte[`PSEL_BIT]; // RL3 RL4
         end else if (wr_idx == `IDX_CLOCK_CTRL) begin
            clk_ctrl_q <= wr_byte; // RL6
         end else if (wr_idx == `IDX_WAIT_CTRL) begin
            if (ta_open) begin
               wait_en_q <= wr_byte[`WAIT_EN_BIT]; // RL15
            end
         end
      end
   end

   // unlock: AAh arms, 55h next opens a short window, any other value disarms
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ta_armed_q  <= 1'b0;
         ta_window_q <= 8'h00;
      end else if (wr_commit && wr_idx == `IDX_TIMED_ACCESS) begin
         ta_armed_q <= (wr_byte == `TA_KEY_FIRST); // RL19
         if (ta_armed_q && wr_byte == `TA_KEY_SECOND) begin
            ta_window_q <= TA_WIN_CLKS[7:0]; // RL19
         end else begin
            ta_window_q <= 8'h00;
         end
      end else if (wr_commit && wr_idx == `IDX_WAIT_CTRL) begin
         ta_window_q <= 8'h00; // one protected write per unlock
      end else if (ta_open) begin
         ta_window_q <= ta_window_q - 8'h01;
      end
   end

   // transfer sequencer: the fetch cycle is the cpu's, access cycles are ours
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q    <= ST_IDLE;
         first_q    <= 1'b0;
         short_q    <= 1'b0;
         cyc_left_q <= 3'h0;
         ext_q      <= 1'b0;
         write_q    <= 1'b0;
         addr_q     <= 16'h0000;
         wdata_q    <= 8'h00;
         oe_q       <= 1'b0;
         rd_n_q     <= 1'b1;
         wr_n_q     <= 1'b1;
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
         xrdata_q   <= 8'h00;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // request seen in C4 of the fetch; access opens at the next C1
               if (phase == `PH_C4 && xfer_req_i) begin // RL5
                  state_q    <= ST_ACCESS;
                  busy_q     <= 1'b1; // RL9
                  first_q    <= 1'b1;
                  short_q    <= (stretch == 3'h0);
                  cyc_left_q <= stretch; // RL7
                  ext_q      <= 1'b0;
                  write_q    <= xfer_write_i;
                  wdata_q    <= xfer_wdata_i;
                  oe_q       <= xfer_write_i;
                  if (xfer_use_ptr_i) begin
                     addr_q <= sel_ptr; // RL2
                  end else begin
                     addr_q <= {port2_latch_i, bank_index_i}; // RL1
                  end
               end
            end
            ST_ACCESS: begin
               case (phase)
                  `PH_C1: begin
                     // stretch 0: strobe from C2 of first cycle to C3 of last
                     if (first_q && short_q) begin // RL8
                        rd_n_q <= write_q; // RL21
                        wr_n_q <= ~write_q; // RL21
                     end
                  end
                  `PH_C3: begin
                     // stretched: strobe from C4 of first cycle to C3 of last
                     if (first_q && !short_q) begin // RL8
                        rd_n_q <= write_q; // RL21
                        wr_n_q <= ~write_q; // RL21
                     end
                     // wait is judged in C3, before the strobe would rise
                     if (cyc_left_q == 3'h0) begin
                        if (wait_en_q && wait_act) begin // RL11 RL12 RL13
                           ext_q <= 1'b1;
                        end else begin
                           rd_n_q <= 1'b1; // RL8 RL14
                           wr_n_q <= 1'b1;
                        end
                     end
                  end
                  `PH_C4: begin
                     first_q <= 1'b0;
                     if (cyc_left_q != 3'h0) begin
                        cyc_left_q <= cyc_left_q - 3'h1; // RL7
                     end else if (ext_q) begin
                        ext_q <= 1'b0; // RL13 RL14
                     end else begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        oe_q    <= 1'b0;
                        if (!write_q) begin
                           xrdata_q <= ext_data_sync;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // every output straight from a flop
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = waitreq_q;
   assign xfer_busy_o     = busy_q;
   assign xfer_done_o     = done_q;
   assign xfer_rdata_o    = xrdata_q;
   assign phase_o         = phase;
   assign ext_addr_o      = addr_q;
   assign ext_data_o      = wdata_q;
   assign ext_data_oe_o   = oe_q;
   assign ext_rd_n_o      = rd_n_q;
   assign ext_wr_n_o      = wr_n_q;

endmodule // xdata_access
`default_nettype wire

// *** src/xdata_map.vh ***
// register map, field positions, reset values and timing counts of the external data access block
// What this block does
// RL1 - Index form: low address byte from bank index register, high from port-2 latch.
// RL2 - Pointer form: full sixteen-bit address comes from the selected data pointer.
// RL3 - Two data pointers; pointer_select bit 0 at 86h picks a (0) or b (1).
// RL4 - Bits 7 to 1 of pointer_select do nothing and always read zero.
// RL5 - Transfer starts with an opcode fetch cycle; access begins the next machine cycle.
// RL6 - Stretch field sits in bits 2 to 0 of clock_control_reg, eight durations.
// RL7 - Stretch n makes the transfer last n plus 2 machine cycles.
// RL8 - Strobe lasts 2 clocks at stretch 0, otherwise 4 clocks per stretch step.
// RL9 - Stretching lengthens only the transfer, as if CPU state were frozen.
// RL10 - Stretch field resets to 1, giving three machine cycle transfers.
// RL11 - Wait control works only while bit 7 of wait_control_reg is set.
// RL12 - With wait enabled stretch gives minimum length; wait sampled in C3.
// RL13 - Each sampled wait assertion inserts one more machine cycle next.
// RL14 - No limit on wait cycles; transfer ends in cycle where wait is seen released.
// RL15 - Wait enable changes only after the timed access unlock; other writes ignored.
// RL16 - Software should pair wait enable with stretch 0 when relying on wait.
// RL17 - Wait input is the alternate function of port4_bit0, larger packages only.
// RL18 - A machine cycle is four clock states C1, C2, C3, C4 in order.
// RL19 - Protected write needs AAh then 55h written to timed_access_reg first.
// RL20 - Wait input is active low and synchronised before being sampled in C3.
// RL21 - Read strobe only for reads, write strobe only for writes, idle otherwise.
`ifndef XDATA_MAP_VH
`define XDATA_MAP_VH

// register indices, byte address is four times the index
`define IDX_DATA_POINTER_A_A_LO    8'h82
`define IDX_DATA_POINTER_A_A_HI    8'h83
`define IDX_DATA_POINTER_A_B_LO    8'h84
`define IDX_DATA_POINTER_A_B_HI    8'h85
`define IDX_PTR_SELECT   8'h86
`define IDX_CLOCK_CTRL   8'h8E
`define IDX_WAIT_CTRL    8'h91
`define IDX_XFER_STATUS  8'h92
`define IDX_TIMED_ACCESS 8'hC7

// field positions
`define PSEL_BIT         0
`define STRETCH_MSB      2
`define STRETCH_LSB      0
`define WAIT_EN_BIT      7
`define STAT_BUSY_BIT    0
`define STAT_WAITING_BIT 1
`define STAT_WAIT_EN_BIT 2

// reset values
`define CLOCK_CTRL_RST   8'h01
`define PTR_RST          16'h0000

// timed access unlock codes
`define TA_KEY_FIRST     8'hAA
`define TA_KEY_SECOND    8'h55

// machine cycle states
`define PH_C1            2'h0
`define PH_C2            2'h1
`define PH_C3            2'h2
`define PH_C4            2'h3

// timing: clock period and unlock window
`define CLK_PERIOD_NS    5
`define TA_WINDOW_MC     3
`define CLOCKS_PER_MC    4
`define TA_WINDOW_CLKS   (`TA_WINDOW_MC * `CLOCKS_PER_MC)

`endif

// *** tb/ext_mem_model.sv ***
// external data memory with a wait pin, far side of the transfer bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   // clock
   input  wire logic        mclk_i,
   // bus from the block
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        oe_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   // machine cycles of wait to ask for, 0 for none
   input  wire logic [3:0]  wait_mc_i,
   // answers
   output wire logic [7:0]  data_o,
   output wire logic        wait_n_o
);
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;
   logic [5:0] act_q = 6'h00;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
   // released bus toggles every cycle so a stale byte never passes
   assign data_o = !rd_n_i ? mem[addr_i[7:0]] : ~last_q;
   // active low wait held until enough strobe clocks passed
   assign wait_n_o = !(wait_mc_i != 4'h0 && act_q < {wait_mc_i, 2'b00} - 6'h02);
   // strobe clock count and write capture
   always @(posedge mclk_i) begin
      last_q <= data_o;
      act_q <= (rd_n_i && wr_n_i) ? 6'h00 : act_q + 6'h01;
      if (!wr_n_i && oe_i) mem[addr_i[7:0]] <= data_i;
   end
endmodule // ext_mem_model
`default_nettype wire

// *** tb/xdata_access_chk.sv ***
// assertion checker bound to the external data access block
`timescale 1ns/1ps
`default_nettype none
module xdata_access_chk (
   // clock and reset
   input wire logic       mclk_i,
   input wire logic       rstn_i,
   // watched ports
   input wire logic       xfer_req_i,
   input wire logic       xfer_busy_o,
   input wire logic       xfer_done_o,
   input wire logic [1:0] phase_o,
   input wire logic       ext_data_oe_o,
   input wire logic       ext_rd_n_o,
   input wire logic       ext_wr_n_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   // past guard skips the first edge after release, where phase still shows reset
   a_phase_step: assert property (
      $past(rstn_i) |-> phase_o == $past(phase_o) + 2'h1) else $error("phase skipped");
   a_take_busy: assert property (
      phase_o == 2'h3 && xfer_req_i && !xfer_busy_o |=> xfer_busy_o) else $error("not taken");
   a_busy_start: assert property (
      $rose(xfer_busy_o) |-> phase_o == 2'h0) else $error("access not in C1");
   a_done_end: assert property (
      xfer_done_o |-> $fell(xfer_busy_o) && phase_o == 2'h0) else $error("done misplaced");
   // strobe shape: starts in C2 or C4, ends in C4 of the last cycle
   a_strobe_fall: assert property (
      $fell(ext_rd_n_o) || $fell(ext_wr_n_o) |-> phase_o[0]) else $error("strobe start");
   a_strobe_end: assert property (
      $rose(ext_rd_n_o) || $rose(ext_wr_n_o) |-> phase_o == 2'h3 ##1 xfer_done_o)
      else $error("strobe end");
   a_strobe_excl: assert property (ext_rd_n_o || ext_wr_n_o)
      else $error("both strobes");
   a_idle_quiet: assert property (!xfer_busy_o |-> ext_rd_n_o && ext_wr_n_o)
      else $error("strobe while idle");
   a_read_float: assert property (!ext_rd_n_o |-> !ext_data_oe_o)
      else $error("driving during read");
   // main scenarios
   c_read: cover property ($fell(ext_rd_n_o));
   c_write: cover property ($fell(ext_wr_n_o));
   c_long: cover property (xfer_busy_o [*8]);
endmodule // xdata_access_chk
bind xdata_access xdata_access_chk u_xdata_access_chk (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .xfer_req_i(xfer_req_i), .xfer_busy_o(xfer_busy_o),
   .xfer_done_o(xfer_done_o), .phase_o(phase_o), .ext_data_oe_o(ext_data_oe_o),
   .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o));
`default_nettype wire

// *** tb/xdata_access_tb.sv ***
// self-checking testbench for the external data access block
`timescale 1ns/1ps
`default_nettype none
module xdata_access_tb;
   // stimulus and observed nets
   logic        mclk_i = 1'b0, rstn_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [9:0]  avs_address = 10'h000;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic        xreq = 1'b0, xwr = 1'b0, xptr = 1'b0;
   logic [7:0]  bank = 8'h00, p2 = 8'h12, wdat = 8'h00;
   logic [3:0]  wait_mc = 4'h0;
   wire  [31:0] avs_readdata;
   wire  [15:0] addr;
   wire  [7:0]  rdat, edo, edi;
   wire  [1:0]  phase;
   wire         avs_waitrequest, busy, done, oe, rd_n, wr_n, wait_n;
   int          errors = 0, checks = 0;
   xdata_access #(.HAS_WAIT_PIN(1)) u_xdata_access (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .xfer_req_i(xreq), .xfer_write_i(xwr),
      .xfer_use_ptr_i(xptr), .bank_index_i(bank), .port2_latch_i(p2), .xfer_wdata_i(wdat),
      .xfer_busy_o(busy), .xfer_done_o(done), .xfer_rdata_o(rdat), .phase_o(phase),
      .ext_addr_o(addr), .ext_data_o(edo), .ext_data_oe_o(oe), .ext_data_i(edi),
      .ext_rd_n_o(rd_n), .ext_wr_n_o(wr_n), .port4_bit0_n_i(wait_n));
   ext_mem_model u_ext_mem_model (
      .mclk_i(mclk_i), .addr_i(addr), .data_i(edo), .oe_i(oe), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .wait_mc_i(wait_mc), .data_o(edi), .wait_n_o(wait_n));
   // 200 MHz clock
   initial forever #2.5 mclk_i = ~mclk_i;
   task automatic results;
      if (errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // avalon access: request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      int n;
      @(posedge mclk_i);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, wd};
      avs_write <= w;
      avs_read <= !w;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk_i);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 50) begin
         chk("bus timeout", 16'h0000, 16'h0001);
         results;
      end
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      bus(1'b0, idx, 8'h00, v);
      chk("register", {8'h00, exp}, {8'h00, v});
   endtask
   // one transfer; lat counts edges from the take edge to done, sw strobe clocks
   task automatic xfer(input logic w, input logic p, input logic [7:0] bk,
                       input logic [7:0] wd, output int lat, output int sw);
      int n;
      logic tk;
      tk = 1'b0;
      lat = 0;
      sw = 0;
      @(posedge mclk_i);
      xreq <= 1'b1;
      xwr <= w;
      xptr <= p;
      bank <= bk;
      wdat <= wd;
      for (n = 0; n < 300; n++) begin
         @(posedge mclk_i);
         if (tk) begin
            lat++;
            if (rd_n === 1'b0 || wr_n === 1'b0) sw++;
            if (done === 1'b1) break;
         end else if (phase === 2'h3) begin
            tk = 1'b1;
            xreq <= 1'b0;
         end
      end
      if (n == 300) begin
         chk("transfer timeout", 16'h0000, 16'h0001);
         results;
      end
   endtask
   // main sequence
   initial begin
      logic [7:0] v;
      logic [15:0] ea;
      int lat, sw, n;
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rdc(8'h8E, 8'h01);
      rdc(8'h86, 8'h00);
      rdc(8'h10, 8'h00);
      bus(1'b1, 8'h86, 8'hFF, v);
      rdc(8'h86, 8'h01);
      bus(1'b1, 8'h82, 8'h34, v);
      bus(1'b1, 8'h83, 8'h12, v);
      bus(1'b1, 8'h84, 8'hCD, v);
      bus(1'b1, 8'h85, 8'hAB, v);
      xfer(1'b1, 1'b1, 8'h00, 8'hC3, lat, sw);
      chk("address", 16'hABCD, addr);
      chk("length", 16'h0009, 16'(lat));
      chk("strobe", 16'h0004, 16'(sw));
      xfer(1'b0, 1'b1, 8'h00, 8'h00, lat, sw);
      chk("read data", 16'h00C3, {8'h00, rdat});
      bus(1'b1, 8'h86, 8'h00, v);
      for (n = 0; n < 8; n++) begin
         bus(1'b1, 8'h8E, 8'(n), v);
         xfer(1'b0, n[0], 8'h77, 8'h00, lat, sw);
         ea = n[0] ? 16'h1234 : 16'h1277;
         chk("address", ea, addr);
         chk("length", 16'(4 * n + 5), 16'(lat));
         chk("strobe", n == 0 ? 16'h0002 : 16'(4 * n), 16'(sw));
         chk("read data", {8'h00, ea[7:0] ^ 8'h5A}, {8'h00, rdat});
      end
      bus(1'b1, 8'h8E, 8'h00, v);
      bus(1'b1, 8'h91, 8'h80, v);
      bus(1'b0, 8'h92, 8'h00, v);
      chk("wait enable", 16'h0000, {15'h0000, v[2]});
      wait_mc <= 4'h2;
      xfer(1'b0, 1'b0, 8'h77, 8'h00, lat, sw);
      chk("length", 16'h0005, 16'(lat));
      bus(1'b1, 8'hC7, 8'hAA, v);
      bus(1'b1, 8'hC7, 8'h55, v);
      bus(1'b1, 8'h91, 8'h80, v);
      bus(1'b0, 8'h92, 8'h00, v);
      chk("wait enable", 16'h0001, {15'h0000, v[2]});
      for (n = 2; n < 6; n += 3) begin
         wait_mc <= 4'(n);
         xfer(1'b0, 1'b0, 8'h77, 8'h00, lat, sw);
         chk("length", 16'(4 * n + 5), 16'(lat));
         chk("strobe", 16'(4 * n + 2), 16'(sw));
         chk("read data", 16'h002D, {8'h00, rdat});
      end
      results;
   end
endmodule // xdata_access_tb
`default_nettype wire
